// ---- pkg/dsbe_consts.vh ----
// Constants for the data-space banking and EEPROM write controller
`ifndef DSBE_CONSTS_VH
`define DSBE_CONSTS_VH

// Data-space register offsets
`define DSBE_ADDR_WINDOW   8'hC9
`define DSBE_ADDR_BANK     8'hE8
`define DSBE_ADDR_DDC_CTL  8'hE9
`define DSBE_ADDR_EE_CTL   8'hEA

// Data-space areas, selected by address bits 7:6
`define DSBE_AREA_BANK     2'h0
`define DSBE_AREA_ROMWIN   2'h1
`define DSBE_AREA_RAM      2'h2

// Control register fields
`define DSBE_CTL_EN        0
`define DSBE_CTL_BUSY      1
`define DSBE_CTL_PE        2
`define DSBE_CTL_PS        3
`define DSBE_CTL_SB        6
`define DSBE_CTL_RESET     8'h00

// Bank select codes; bit 6 is reserved and ignored by the decoder
`define DSBE_BANK_IGNORE   8'hBF
`define DSBE_BANK_EE0      8'h01
`define DSBE_BANK_EE1      8'h02
`define DSBE_BANK_EE2      8'h03
`define DSBE_BANK_RAM2     8'h04
`define DSBE_BANK_RAM3     8'h08
`define DSBE_BANK_DDC0     8'h10
`define DSBE_BANK_DDC1     8'h20
`define DSBE_BANK_EE3      8'h81
`define DSBE_BANK_EE4      8'h82
`define DSBE_BANK_EE5      8'h83
`define DSBE_WINDOW_RESET  8'h00
`define DSBE_BANK_RESET    8'h00

// Array sizes
`define DSBE_EE_BYTES      384
`define DSBE_DDC_BYTES     128
`define DSBE_ROW_BYTES     8

// Write time: 5 ms at 100000 kHz
`define DSBE_WRITE_TIME_MS 5
`define DSBE_CLK_KHZ       100000
`define DSBE_WRITE_CYCLES  (`DSBE_WRITE_TIME_MS * `DSBE_CLK_KHZ)
`define DSBE_WAIT_W        19

`endif

// ---- core/dsbe_ee_engine.v ----
// One EEPROM array with its control register, row latches and write timer
`include "dsbe_consts.vh"

module dsbe_ee_engine #(
    parameter integer DEPTH        = `DSBE_EE_BYTES,
    parameter integer AW           = 9,
    parameter integer WRITE_CYCLES = `DSBE_WRITE_CYCLES
) (
    input  wire          clk_i,
    input  wire          sys_rst_i,
    input  wire          ctl_wr_i,
    input  wire [7:0]    ctl_wdata_i,
    input  wire          mem_wr_i,
    input  wire [AW-1:0] mem_addr_i,
    input  wire [7:0]    mem_wdata_i,
    output wire [7:0]    mem_rdata_o,
    output wire [7:0]    ctl_rdata_o,
    output wire          busy_o,
    output wire          sleep_o
);
    localparam [31:0] LOAD32 = WRITE_CYCLES - 1;
    localparam [`DSBE_WAIT_W-1:0] WAIT_LOAD = LOAD32[`DSBE_WAIT_W-1:0];

    reg [7:0]              mem [0:DEPTH-1];
    reg [7:0]              row_latch [0:`DSBE_ROW_BYTES-1];
    reg [7:0]              row_loaded;
    reg [AW-4:0]           row_addr;
    reg                    row_valid;
    reg                    write_enable;
    reg                    row_load_mode;
    reg                    row_program_go;
    reg                    array_sleep;
    reg                    write_in_progress;
    reg [AW-1:0]           pend_addr;
    reg [7:0]              pend_data;
    reg [`DSBE_WAIT_W-1:0] wait_cnt;
    integer                i;
    integer                j;

    // Control writes are dropped while busy; start needs unlock and row mode
    wire ctl_take = ctl_wr_i & ~write_in_progress;
    wire go_ok    = ctl_wdata_i[`DSBE_CTL_PS] & ctl_wdata_i[`DSBE_CTL_EN]
                  & ctl_wdata_i[`DSBE_CTL_PE] & row_load_mode;
    wire wr_ok    = mem_wr_i & write_enable & ~array_sleep
                  & ~write_in_progress;
    wire done     = write_in_progress & (wait_cnt == {`DSBE_WAIT_W{1'b0}});
    wire same_row = ~row_valid | (row_addr == mem_addr_i[AW-1:3]);

    // Control state, row latches and timer
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            write_enable      <= 1'b0;
            row_load_mode     <= 1'b0;
            row_program_go    <= 1'b0;
            array_sleep       <= 1'b0;
            write_in_progress <= 1'b0;
            row_valid         <= 1'b0;
            row_loaded        <= 8'h00;
            row_addr          <= {(AW-3){1'b0}};
            pend_addr         <= {AW{1'b0}};
            pend_data         <= 8'h00;
            wait_cnt          <= {`DSBE_WAIT_W{1'b0}};
            for (i = 0; i < `DSBE_ROW_BYTES; i = i + 1) begin
                row_latch[i] <= 8'h00;
            end
        end else begin
            if (done) begin
                write_in_progress <= 1'b0;
                if (row_program_go) begin
                    row_program_go <= 1'b0;
                    row_load_mode  <= 1'b0;
                    row_valid      <= 1'b0;
                    row_loaded     <= 8'h00;
                end
            end else if (write_in_progress) begin
                wait_cnt <= wait_cnt - 1'b1;
            end
            if (ctl_take) begin
                write_enable <= ctl_wdata_i[`DSBE_CTL_EN];
                array_sleep  <= ctl_wdata_i[`DSBE_CTL_SB];
                row_load_mode <= ctl_wdata_i[`DSBE_CTL_PE];
                // Entering or leaving row mode empties the latches
                if (ctl_wdata_i[`DSBE_CTL_PE] != row_load_mode) begin
                    row_valid  <= 1'b0;
                    row_loaded <= 8'h00;
                    for (i = 0; i < `DSBE_ROW_BYTES; i = i + 1) begin
                        row_latch[i] <= 8'h00;
                    end
                end
                if (go_ok) begin
                    row_program_go    <= 1'b1;
                    write_in_progress <= 1'b1;
                    wait_cnt          <= WAIT_LOAD;
                end
            end else if (wr_ok) begin
                if (row_load_mode) begin
                    // Other rows after the first write are ignored
                    if (same_row) begin
                        row_valid <= 1'b1;
                        row_addr  <= mem_addr_i[AW-1:3];
                        row_latch[mem_addr_i[2:0]]  <= mem_wdata_i;
                        row_loaded[mem_addr_i[2:0]] <= 1'b1;
                    end
                end else begin
                    pend_addr         <= mem_addr_i;
                    pend_data         <= mem_wdata_i;
                    write_in_progress <= 1'b1;
                    wait_cnt          <= WAIT_LOAD;
                end
            end
        end
    end

    // Array commit at the end of the write time; unloaded row bytes keep old data
    always @(posedge clk_i) begin
        if (done) begin
            if (row_program_go) begin
                // Own loop index, so the control process stays the only driver of i
                for (j = 0; j < `DSBE_ROW_BYTES; j = j + 1) begin
                    if (row_loaded[j]) begin
                        mem[{row_addr, j[2:0]}] <= row_latch[j];
                    end
                end
            end else begin
                mem[pend_addr] <= pend_data;
            end
        end
    end

    // Reads see zero while busy or asleep
    assign mem_rdata_o = (write_in_progress | array_sleep) ? 8'h00
                       : mem[mem_addr_i];
    assign ctl_rdata_o = {6'h00, write_in_progress, 1'b0};
    assign busy_o      = write_in_progress;
    assign sleep_o     = array_sleep;
endmodule // dsbe_ee_engine

// ---- core/dsbe_ctrl.v ----
// Data-space paging, data ROM window and EEPROM write control
`include "dsbe_consts.vh"

module dsbe_ctrl #(
    parameter integer WRITE_CYCLES = `DSBE_WRITE_CYCLES
) (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire [7:0]  ds_addr_i,
    input  wire [7:0]  ds_wdata_i,
    input  wire        ds_wr_i,
    input  wire        ds_rd_i,
    output reg  [7:0]  ds_rdata_o,
    output wire [13:0] rom_addr_o,
    input  wire [7:0]  rom_data_i,
    output wire        ee_busy_o,
    output wire        ddc_busy_o,
    output wire        ee_sleep_o,
    output wire        ddc_sleep_o
);
    // Bank decoder results
    localparam [3:0] SEL_NONE = 4'h0;
    localparam [3:0] SEL_EE0  = 4'h1;
    localparam [3:0] SEL_EE5  = 4'h6;
    localparam [3:0] SEL_RAM2 = 4'h7;
    localparam [3:0] SEL_RAM3 = 4'h8;
    localparam [3:0] SEL_DDC0 = 4'h9;
    localparam [3:0] SEL_DDC1 = 4'hA;

    reg [7:0] data_rom_window;
    reg [7:0] data_bank_select;
    reg [7:0] ram_direct [0:63];
    reg [7:0] ram_paged  [0:127];

    wire [7:0] ee_rdata;
    wire [7:0] ddc_rdata;
    wire [7:0] ee_ctl_rdata;
    wire [7:0] ddc_ctl_rdata;

    // Bank code to selection; bit 6 is reserved, so it is not decoded
    function [3:0] dsbe_bank_sel;
        input [7:0] code;
        begin
            case (code & `DSBE_BANK_IGNORE)
                `DSBE_BANK_EE0:  dsbe_bank_sel = 4'h1;
                `DSBE_BANK_EE1:  dsbe_bank_sel = 4'h2;
                `DSBE_BANK_EE2:  dsbe_bank_sel = 4'h3;
                `DSBE_BANK_EE3:  dsbe_bank_sel = 4'h4;
                `DSBE_BANK_EE4:  dsbe_bank_sel = 4'h5;
                `DSBE_BANK_EE5:  dsbe_bank_sel = 4'h6;
                `DSBE_BANK_RAM2: dsbe_bank_sel = 4'h7;
                `DSBE_BANK_RAM3: dsbe_bank_sel = 4'h8;
                `DSBE_BANK_DDC0: dsbe_bank_sel = 4'h9;
                `DSBE_BANK_DDC1: dsbe_bank_sel = 4'hA;
                default:         dsbe_bank_sel = 4'h0;
            endcase
        end
    endfunction

    // Address decode
    wire [1:0] area     = ds_addr_i[7:6];
    wire       in_bank  = (area == `DSBE_AREA_BANK);
    wire       in_ram   = (area == `DSBE_AREA_RAM);
    wire       in_rom   = (area == `DSBE_AREA_ROMWIN);
    wire [3:0] sel      = dsbe_bank_sel(data_bank_select);
    wire       sel_ee   = (sel >= SEL_EE0) && (sel <= SEL_EE5);
    wire       sel_ram  = (sel == SEL_RAM2) || (sel == SEL_RAM3);
    wire       sel_ddc  = (sel == SEL_DDC0) || (sel == SEL_DDC1);
    wire [3:0] ee_page  = sel - SEL_EE0;

    // Array indices formed from the page and the low six address bits
    wire [8:0] ee_addr  = {ee_page[2:0], ds_addr_i[5:0]};
    wire [6:0] ddc_addr = {(sel == SEL_DDC1), ds_addr_i[5:0]};
    wire [6:0] ram_idx  = {(sel == SEL_RAM3), ds_addr_i[5:0]};

    wire ee_mem_wr  = ds_wr_i & in_bank & sel_ee;
    wire ddc_mem_wr = ds_wr_i & in_bank & sel_ddc;
    wire ee_ctl_wr  = ds_wr_i & (ds_addr_i == `DSBE_ADDR_EE_CTL);
    wire ddc_ctl_wr = ds_wr_i & (ds_addr_i == `DSBE_ADDR_DDC_CTL);

    // Program-memory address of the window; the ROM answers combinationally
    assign rom_addr_o = {data_rom_window, ds_addr_i[5:0]};

    // Write-only paging registers; reset to zero so outputs are defined
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            data_rom_window  <= `DSBE_WINDOW_RESET;
            data_bank_select <= `DSBE_BANK_RESET;
        end else if (ds_wr_i) begin
            if (ds_addr_i == `DSBE_ADDR_WINDOW) begin
                data_rom_window <= ds_wdata_i;
            end
            if (ds_addr_i == `DSBE_ADDR_BANK) begin
                data_bank_select <= ds_wdata_i;
            end
        end
    end

    // RAM storage, direct and banked; no reset since contents are data
    always @(posedge clk_i) begin
        if (ds_wr_i & in_ram) begin
            ram_direct[ds_addr_i[5:0]] <= ds_wdata_i;
        end
        if (ds_wr_i & in_bank & sel_ram) begin
            ram_paged[ram_idx] <= ds_wdata_i;
        end
    end

    // Read data registered one cycle after the strobe
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ds_rdata_o <= 8'h00;
        end else if (ds_rd_i) begin
            if (in_ram) begin
                ds_rdata_o <= ram_direct[ds_addr_i[5:0]];
            end else if (in_rom) begin
                ds_rdata_o <= rom_data_i;
            end else if (in_bank) begin
                if (sel_ee) begin
                    ds_rdata_o <= ee_rdata;
                end else if (sel_ddc) begin
                    ds_rdata_o <= ddc_rdata;
                end else if (sel_ram) begin
                    ds_rdata_o <= ram_paged[ram_idx];
                end else begin
                    ds_rdata_o <= 8'h00;
                end
            end else if (ds_addr_i == `DSBE_ADDR_EE_CTL) begin
                ds_rdata_o <= ee_ctl_rdata;
            end else if (ds_addr_i == `DSBE_ADDR_DDC_CTL) begin
                ds_rdata_o <= ddc_ctl_rdata;
            end else begin
                // Window and bank registers cannot be read back
                ds_rdata_o <= 8'h00;
            end
        end
    end

    // General-purpose EEPROM, six pages
    dsbe_ee_engine #(
        .DEPTH        (`DSBE_EE_BYTES),
        .AW           (9),
        .WRITE_CYCLES (WRITE_CYCLES)
    ) u_ee (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .ctl_wr_i    (ee_ctl_wr),
        .ctl_wdata_i (ds_wdata_i),
        .mem_wr_i    (ee_mem_wr),
        .mem_addr_i  (ee_addr),
        .mem_wdata_i (ds_wdata_i),
        .mem_rdata_o (ee_rdata),
        .ctl_rdata_o (ee_ctl_rdata),
        .busy_o      (ee_busy_o),
        .sleep_o     (ee_sleep_o)
    );

    // Display-channel EEPROM, two pages, same control layout
    dsbe_ee_engine #(
        .DEPTH        (`DSBE_DDC_BYTES),
        .AW           (7),
        .WRITE_CYCLES (WRITE_CYCLES)
    ) u_ddc (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .ctl_wr_i    (ddc_ctl_wr),
        .ctl_wdata_i (ds_wdata_i),
        .mem_wr_i    (ddc_mem_wr),
        .mem_addr_i  (ddc_addr),
        .mem_wdata_i (ds_wdata_i),
        .mem_rdata_o (ddc_rdata),
        .ctl_rdata_o (ddc_ctl_rdata),
        .busy_o      (ddc_busy_o),
        .sleep_o     (ddc_sleep_o)
    );
endmodule // dsbe_ctrl

// ---- tb/dsbe_ctrl_sva.sv ----
// Port-level assertion checker for the banking and EEPROM controller
module dsbe_ctrl_sva #(
    parameter integer WRITE_CYCLES = 20
) (
    input wire        clk_i,
    input wire        sys_rst_i,
    input wire [7:0]  ds_addr_i,
    input wire [7:0]  ds_wdata_i,
    input wire        ds_wr_i,
    input wire        ds_rd_i,
    input wire [7:0]  ds_rdata_o,
    input wire [13:0] rom_addr_o,
    input wire [7:0]  rom_data_i,
    input wire        ee_busy_o,
    input wire        ddc_busy_o,
    input wire        ee_sleep_o,
    input wire        ddc_sleep_o
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0]  win;
    reg        ee_en;
    reg [31:0] ee_cnt;
    // Shadows of write-only state, since the core can never read them back
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            win    <= 8'h00;
            ee_en  <= 1'b0;
            ee_cnt <= 32'h0;
        end else begin
            if (ds_wr_i && ds_addr_i == 8'hC9)
                win <= ds_wdata_i;
            if (ds_wr_i && ds_addr_i == 8'hEA && !ee_busy_o)
                ee_en <= ds_wdata_i[0];
            ee_cnt <= ee_busy_o ? ee_cnt + 32'h1 : 32'h0;
        end
    end
    default clocking dflt @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Window address, register reads and read data holding
    a_rom_window: assert property (rom_addr_o == {win, ds_addr_i[5:0]})
        else $error("rom address not window plus low bits");
    a_wo_zero: assert property (ds_rd_i && (ds_addr_i == 8'hC9 || ds_addr_i == 8'hE8)
        |=> ds_rdata_o == 8'h00) else $error("write-only register read nonzero");
    a_ctl_readback: assert property (ds_rd_i && ds_addr_i == 8'hEA
        |=> ds_rdata_o == {6'h00, $past(ee_busy_o), 1'b0}) else $error("control read wrong");
    a_rdata_hold: assert property (!ds_rd_i |=> $stable(ds_rdata_o))
        else $error("read data moved without a read");
    // Busy flag cause, length and control freeze
    a_busy_cause: assert property ($rose(ee_busy_o) |-> $past(ds_wr_i))
        else $error("busy rose without a write");
    a_busy_length: assert property ($fell(ee_busy_o) |-> ee_cnt == WRITE_CYCLES)
        else $error("busy length wrong");
    a_busy_bound: assert property (ee_cnt <= WRITE_CYCLES)
        else $error("busy did not clear");
    a_no_unlock: assert property (ds_wr_i && ds_addr_i[7:6] == 2'h0 && !ee_en
        && !ee_busy_o |=> !ee_busy_o) else $error("locked write set busy");
    a_ctl_frozen: assert property (ds_wr_i && ds_addr_i == 8'hEA && ee_busy_o
        |=> $stable(ee_sleep_o)) else $error("control changed while busy");
    a_sleep_write: assert property (ds_wr_i && ds_addr_i == 8'hEA && !ee_busy_o
        |=> ee_sleep_o == $past(ds_wdata_i[6])) else $error("standby bit not taken");
    c_byte_write: cover property ($rose(ee_busy_o));
    c_ddc_write: cover property ($rose(ddc_busy_o));
    c_busy_poll: cover property (ds_rd_i && ds_addr_i == 8'hEA && ee_busy_o);
endmodule // dsbe_ctrl_sva

bind dsbe_ctrl dsbe_ctrl_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ds_addr_i(ds_addr_i),
    .ds_wdata_i(ds_wdata_i), .ds_wr_i(ds_wr_i), .ds_rd_i(ds_rd_i),
    .ds_rdata_o(ds_rdata_o), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
    .ee_busy_o(ee_busy_o), .ddc_busy_o(ddc_busy_o), .ee_sleep_o(ee_sleep_o),
    .ddc_sleep_o(ddc_sleep_o)
);

// ---- tb/dsbe_ctrl_test.sv ----
// Self-checking bench for the banking and EEPROM controller
module dsbe_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer WC = 20;
    reg         clk_i;
    reg         sys_rst_i;
    reg  [7:0]  ds_addr_i;
    reg  [7:0]  ds_wdata_i;
    reg         ds_wr_i;
    reg         ds_rd_i;
    wire [7:0]  ds_rdata_o;
    wire [13:0] rom_addr_o;
    wire [7:0]  rom_data_i;
    wire        ee_busy_o;
    wire        ddc_busy_o;
    wire        ee_sleep_o;
    wire        ddc_sleep_o;
    integer     err_count;
    integer     n_checks;
    integer     i;
    reg  [7:0]  rv;
    reg  [7:0]  codes [0:7];
    reg  [31:0] rows [0:11];
    function automatic [7:0] rom_byte(input [13:0] a);
        rom_byte = a[7:0] ^ {2'h0, a[13:8]};
    endfunction
    // Program memory stand-in, answers in the same cycle
    assign rom_data_i = rom_byte(rom_addr_o);
    dsbe_ctrl #(.WRITE_CYCLES(WC)) dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ds_addr_i(ds_addr_i),
        .ds_wdata_i(ds_wdata_i), .ds_wr_i(ds_wr_i), .ds_rd_i(ds_rd_i),
        .ds_rdata_o(ds_rdata_o), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
        .ee_busy_o(ee_busy_o), .ddc_busy_o(ddc_busy_o), .ee_sleep_o(ee_sleep_o),
        .ddc_sleep_o(ddc_sleep_o)
    );
    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        tick;
        ds_wr_i    = 1'b1;
        ds_addr_i  = a;
        ds_wdata_i = d;
        tick;
        ds_wr_i = 1'b0;
    endtask
    task automatic chk(input [63:0] what, input [7:0] exp, input [7:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input [63:0] what, input exp, input got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0s expected %b seen %b", what, exp, got);
        end
    endtask
    // Read strobe for one cycle; data is registered at the taking edge
    task automatic rdc(input [7:0] a, input [7:0] exp);
        tick;
        ds_rd_i   = 1'b1;
        ds_addr_i = a;
        tick;
        ds_rd_i = 1'b0;
        rv      = ds_rdata_o;
        chk("rdata", exp, rv);
    endtask
    // Bounded wait; a hang is counted as a mismatch here
    task automatic wait_idle;
        integer k;
        k = 0;
        while ((ee_busy_o || ddc_busy_o) && k < 100) begin
            @(posedge clk_i);
            k = k + 1;
        end
        #1;
        chk_flag("idle", 1'b0, ee_busy_o | ddc_busy_o);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog, about fifty times the expected run
    initial begin
        #200000;
        err_count = err_count + 1;
        $display("watchdog expired");
        report_and_stop;
    end
    // Main sequence: table of plain accesses, then hand-written cases
    initial begin
        {sys_rst_i, ds_wr_i, ds_rd_i, ds_addr_i, ds_wdata_i} = {3'h4, 16'h0000};
        err_count = 0;
        n_checks  = 0;
        codes[0] = 8'h01; codes[1] = 8'h02; codes[2] = 8'h03; codes[3] = 8'h81;
        codes[4] = 8'h82; codes[5] = 8'h83; codes[6] = 8'h10; codes[7] = 8'h20;
        rows[0]  = {8'h80, 8'hA5, 8'h80, 8'hA5};
        rows[1]  = {8'hBF, 8'h3C, 8'hBF, 8'h3C};
        rows[2]  = {8'hC9, 8'h12, 8'h47, rom_byte({8'h12, 6'h07})};
        rows[3]  = {8'hC9, 8'hFF, 8'h40, rom_byte({8'hFF, 6'h00})};
        rows[4]  = {8'hC9, 8'h34, 8'hC9, 8'h00};
        rows[5]  = {8'hE8, 8'h04, 8'hE8, 8'h00};
        rows[6]  = {8'h10, 8'h77, 8'h10, 8'h77};
        rows[7]  = {8'hE8, 8'h08, 8'hF5, 8'h00};
        rows[8]  = {8'h10, 8'h88, 8'h10, 8'h88};
        rows[9]  = {8'hE8, 8'h04, 8'h10, 8'h77};
        rows[10] = {8'hE8, 8'h00, 8'h10, 8'h00};
        rows[11] = {8'hF5, 8'h66, 8'hF5, 8'h00};
        repeat (12) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        for (i = 0; i < 12; i = i + 1) begin
            wr(rows[i][31:24], rows[i][23:16]);
            rdc(rows[i][15:8], rows[i][7:0]);
        end
        $display("test table done");
        wr(8'hEA, 8'h01);
        wr(8'hE9, 8'h01);
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'hE8, codes[i]);
            wr(8'h08, 8'hC0 + i[7:0]);
            tick;
            chk_flag("busy", 1'b1, i < 6 ? ee_busy_o : ddc_busy_o);
            rdc(8'hEA, i < 6 ? 8'h02 : 8'h00);
            rdc(8'hE9, i < 6 ? 8'h00 : 8'h02);
            rdc(8'h08, 8'h00);
            wr(i < 6 ? 8'hEA : 8'hE9, 8'h40);
            chk_flag("sleep", 1'b0, ee_sleep_o | ddc_sleep_o);
            wait_idle;
        end
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'hE8, codes[i]);
            rdc(8'h08, 8'hC0 + i[7:0]);
        end
        $display("test byte writes done");
        wr(8'hEA, 8'h00);
        wr(8'hE8, 8'h01);
        wr(8'h08, 8'hFF);
        tick;
        chk_flag("busy", 1'b0, ee_busy_o);
        rdc(8'h08, 8'hC0);
        wr(8'hEA, 8'h41);
        chk_flag("sleep", 1'b1, ee_sleep_o);
        rdc(8'h08, 8'h00);
        wr(8'h08, 8'h11);
        tick;
        chk_flag("busy", 1'b0, ee_busy_o);
        wr(8'hEA, 8'h01);
        chk_flag("sleep", 1'b0, ee_sleep_o);
        rdc(8'h08, 8'hC0);
        $display("test unlock and standby done");
        wr(8'hEA, 8'h09);
        tick;
        chk_flag("busy", 1'b0, ee_busy_o);
        wr(8'hEA, 8'h05);
        wr(8'h18, 8'hA1);
        wr(8'h1A, 8'hA2);
        wr(8'h1B, 8'hA3);
        wr(8'h08, 8'hEE);
        tick;
        chk_flag("busy", 1'b0, ee_busy_o);
        wr(8'hEA, 8'h0D);
        tick;
        chk_flag("busy", 1'b1, ee_busy_o);
        wait_idle;
        rdc(8'h18, 8'hA1);
        rdc(8'h1A, 8'hA2);
        rdc(8'h1B, 8'hA3);
        rdc(8'h08, 8'hC0);
        wr(8'h18, 8'h55);
        tick;
        chk_flag("busy", 1'b1, ee_busy_o);
        wait_idle;
        rdc(8'h18, 8'h55);
        wr(8'hEA, 8'h05);
        wr(8'h18, 8'h77);
        wr(8'hEA, 8'h01);
        wr(8'hEA, 8'h0D);
        tick;
        chk_flag("busy", 1'b0, ee_busy_o);
        rdc(8'h18, 8'h55);
        $display("test row writes done");
        wr(8'hEA, 8'h01);
        wr(8'h18, 8'h66);
        tick;
        chk_flag("busy", 1'b1, ee_busy_o);
        sys_rst_i = 1'b1;
        repeat (2) tick;
        chk_flag("busy", 1'b0, ee_busy_o);
        sys_rst_i = 1'b0;
        rdc(8'hEA, 8'h00);
        rdc(8'h40, rom_byte(14'h0000));
        $display("test reset done");
        report_and_stop;
    end
endmodule // dsbe_ctrl_test
